// ### include/usb_stat_pkg.sv
// Purpose: shared constants and carriers for the usb status/control block
// Assumes: 8-bit register port with word index offsets
// Notes: offsets are register indices on the plain port
package usb_stat_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register indices
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h1;
  localparam logic [3:0] OFF_DEV_ID = 4'h2;
  localparam logic [3:0] OFF_FRAME_LO = 4'h3;
  localparam logic [3:0] OFF_FRAME_HI = 4'h4;
  localparam logic [3:0] OFF_IRQ_FLAGS = 4'h5;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
  // status field positions
  localparam int ST_PIPE_LSB = 4;
  localparam int ST_DIR_BIT = 3;
  localparam int ST_ODD_BIT = 2;
  // control field positions
  localparam int CT_HOLD_BIT = 5;
  localparam int CT_WAKE_BIT = 2;
  localparam int CT_PPCLR_BIT = 1;
  localparam int CT_EN_BIT = 0;
  // interrupt flag positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SETUP_BIT = 1;
  localparam int IRQ_SOF_BIT = 2;
  localparam int IRQ_BUSRST_BIT = 3;
  localparam logic [3:0] IRQ_USED = 4'hF;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [6:0] RST_DEV_ID = 7'h00;
  localparam logic [10:0] RST_FRAME = 11'h000;
  localparam logic [3:0] RST_MASK = 4'h0;
  // fifo sizing
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam logic [2:0] FIFO_FULL_CNT = 3'h4;
  // highest pipe present and first double-buffered pipe
  localparam logic [3:0] PIPE_MAX = 4'h6;
  localparam logic [3:0] PP_FIRST_PIPE = 4'h5;

  // one finished transaction as reported by the serial engine
  typedef struct packed {
    logic [3:0] pipe_index;
    logic is_in;
    logic odd_bank;
  } xfer_status_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;
endpackage

// ### logic/usb_device_status_control.sv
// Purpose: status fifo, control, address and frame registers of a usb
//   full-speed device controller
// Assumes: serial engine events are single-cycle pulses on clk
// Notes: registers sit on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
module usb_device_status_control
  import usb_stat_pkg::*;
(
  input wire logic clk, // 200 MHz module clock
  input wire logic rst_n, // synchronous reset, active low
  input wire usb_stat_pkg::reg_req_s req, // register port request
  output logic [usb_stat_pkg::DATA_W-1:0] rdata, // read data, next cycle
  input wire logic xfer_done, // pulse: descriptor use finished
  input wire usb_stat_pkg::xfer_status_s xfer_info, // with xfer_done
  input wire logic setup_seen, // pulse: setup token received
  input wire logic sof_seen, // pulse: sof token received
  input wire logic [10:0] sof_frame, // frame number with sof_seen
  input wire logic bus_reset_seen, // pulse: usb bus reset detected
  input wire logic [6:0] token_addr, // address field of current token
  output logic addr_match, // enabled and token address equals device address
  output logic token_run, // engine may move packets
  output logic wake_drive, // drive resume signalling on the bus
  output logic engine_reset, // pulse: reset serial engine state
  output logic [6:0] odd_clear, // per pipe odd bit clear pulses
  output logic status_overflow, // pulse: push dropped, fifo full
  output logic irq // level interrupt
);

  // fifo storage and pointers
  xfer_status_s fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [7:0] control;
  logic [6:0] dev_id;
  logic [10:0] frame;
  logic [3:0] irq_flags;
  logic [3:0] irq_mask;

  // register decode
  wire sel_status = req.addr == OFF_STATUS;
  wire sel_control = req.addr == OFF_CONTROL;
  wire sel_dev_id = req.addr == OFF_DEV_ID;
  wire sel_frame_lo = req.addr == OFF_FRAME_LO;
  wire sel_frame_hi = req.addr == OFF_FRAME_HI;
  wire sel_flags = req.addr == OFF_IRQ_FLAGS;
  wire sel_mask = req.addr == OFF_IRQ_MASK;
  wire wr_control = req.wr && sel_control;
  wire wr_flags = req.wr && sel_flags;

  // fifo push/pop; the done flag marks head entry presented to software
  wire fifo_empty = count == '0;
  wire fifo_full = count == FIFO_FULL_CNT;
  wire push = xfer_done && !fifo_full;
  // clearing the done flag retires the head entry
  wire done_clear = wr_flags && req.wdata[IRQ_DONE_BIT]
    && irq_flags[IRQ_DONE_BIT];
  wire pop = done_clear && !fifo_empty;
  wire [PTR_W:0] count_up = count + 1'b1;
  wire [PTR_W:0] count_dn = count - 1'b1;
  wire [PTR_W:0] next_count = (push && !pop) ? count_up
    : (pop && !push) ? count_dn : count;
  // done flag stands whenever an entry is waiting after this cycle
  wire next_done = next_count != '0;

  // status register image from head entry
  xfer_status_s head;
  assign head = fifo_mem[rd_ptr];
  wire [7:0] status_img = irq_flags[IRQ_DONE_BIT]
    ? {head.pipe_index, head.is_in, head.odd_bank, 2'b00}
    : 8'h00;

  // control write effects
  wire en_rise = wr_control && req.wdata[CT_EN_BIT]
    && !control[CT_EN_BIT];
  wire pp_clear = wr_control && req.wdata[CT_PPCLR_BIT];
  // hardware set of the hold bit wins over a software clear
  wire next_hold = setup_seen
    || (wr_control ? req.wdata[CT_HOLD_BIT] : control[CT_HOLD_BIT]);

  // sticky flag sets; hardware set wins over write-one-to-clear
  wire [3:0] flag_set = {bus_reset_seen, sof_seen, setup_seen, 1'b0};
  wire [3:0] flag_clr = wr_flags ? req.wdata[3:0] : 4'h0;
  wire [3:0] next_flags_hi = (irq_flags & ~flag_clr) | flag_set;
  wire [3:0] next_flags = {next_flags_hi[3:1], next_done};

  // read mux
  wire [7:0] read_mux = sel_status ? status_img
    : sel_control ? control
    : sel_dev_id ? {1'b0, dev_id}
    : sel_frame_lo ? frame[7:0]
    : sel_frame_hi ? {5'b00000, frame[10:8]}
    : sel_flags ? {4'h0, irq_flags}
    : sel_mask ? {4'h0, irq_mask}
    : 8'h00;

  // fifo storage write; entries hold no reset value, head gated by flag
  always_ff @(posedge clk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= xfer_info;
  end

  // fifo pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n || en_rise || bus_reset_seen)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= next_count;
    end
  end

  // control register; bit 1 is a command and never stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      control <= RST_CONTROL;
    else
    begin
      control[CT_EN_BIT] <= wr_control ? req.wdata[CT_EN_BIT]
        : control[CT_EN_BIT];
      control[CT_WAKE_BIT] <= wr_control ? req.wdata[CT_WAKE_BIT]
        : control[CT_WAKE_BIT];
      control[CT_HOLD_BIT] <= next_hold;
      control[CT_PPCLR_BIT] <= 1'b0;
      control[7:6] <= 2'b00;
      control[4:3] <= 2'b00;
    end
  end

  // device address, cleared also by usb bus reset
  always_ff @(posedge clk)
  begin
    if (!rst_n || bus_reset_seen)
      dev_id <= RST_DEV_ID;
    else if (req.wr && sel_dev_id)
      dev_id <= req.wdata[6:0];
  end

  // frame number captured on each sof
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      frame <= RST_FRAME;
    else if (sof_seen)
      frame <= sof_frame;
  end

  // interrupt flags and mask
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_flags <= 4'h0;
      irq_mask <= RST_MASK;
    end
    else
    begin
      // a flush by enable or usb bus reset empties the fifo, so the done
      // flag must drop with it or software would read a stale head
      irq_flags <= (en_rise || bus_reset_seen) ? {next_flags[3:1], 1'b0}
        : next_flags;
      irq_mask <= (req.wr && sel_mask) ? req.wdata[3:0] : irq_mask;
    end
  end

  // registered read data, zero when no read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= req.rd ? read_mux : 8'h00;
  end

  // odd-bit clear pulses; pipes 0..4 are single buffered and pulsed only on an enable rise
  genvar p;
  generate
    for (p = 0; p <= PIPE_MAX; p++)
    begin : g_odd
      localparam logic [3:0] PIPE_ID = 4'(p);
      wire pp_hit = pp_clear && (PIPE_ID >= PP_FIRST_PIPE);
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          odd_clear[p] <= 1'b0;
        else
          odd_clear[p] <= pp_hit || en_rise;
      end
    end
  endgenerate

  // outputs to the serial engine
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      engine_reset <= 1'b0;
      status_overflow <= 1'b0;
    end
    else
    begin
      engine_reset <= en_rise;
      status_overflow <= xfer_done && fifo_full;
    end
  end

  // the halt bit gates traffic; a disabled module moves nothing
  assign token_run = control[CT_EN_BIT] && !control[CT_HOLD_BIT];
  assign wake_drive = control[CT_WAKE_BIT];
  assign addr_match = control[CT_EN_BIT] && token_addr == dev_id;
  assign irq = |(irq_flags & irq_mask);

endmodule // usb_device_status_control

// ### testbench/usb_status_props.sv
// Purpose: port checks for the usb status/control block
// Assumes: one clock, synchronous active-low reset
// Notes: attached to the design by the bind at the foot
`timescale 1ns/1ps
module usb_status_props
  import usb_stat_pkg::*;
(
  input logic clk, // clock
  input logic rst_n, // reset
  input usb_stat_pkg::reg_req_s req, // request
  input logic [7:0] rdata, // read data
  input logic xfer_done, // done pulse
  input logic setup_seen, // setup
  input logic bus_reset_seen, // bus reset
  input logic [6:0] token_addr, // token address
  input logic addr_match, // hit
  input logic token_run, // run
  input logic wake_drive, // resume
  input logic engine_reset, // engine reset
  input logic [6:0] odd_clear, // bank clears
  input logic status_overflow // dropped push
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // control writes are the cause behind most outputs below
  wire ctl_wr = req.wr && req.addr == OFF_CONTROL;
  wire en_wr = ctl_wr && req.wdata[CT_EN_BIT];
  a_overflow_cause:
    assert property (status_overflow |-> $past(xfer_done)) else $error("drop");
  a_setup_halts:
    assert property (setup_seen |=> !token_run) else $error("no halt");
  a_halt_holds:
    assert property (!token_run && !ctl_wr && !bus_reset_seen |=> !token_run)
    else $error("halt lost");
  a_wake_follows:
    assert property (ctl_wr |=> wake_drive == $past(req.wdata[CT_WAKE_BIT]))
    else $error("resume drive wrong");
  a_bank_clear:
    assert property (ctl_wr && req.wdata[CT_PPCLR_BIT] |=> &odd_clear[6:5])
    else $error("bank clear missing");
  a_low_pipes_kept:
    assert property (|odd_clear[4:0] |-> &odd_clear && engine_reset)
    else $error("low pipe cleared");
  a_enable_reset:
    assert property (engine_reset |-> &odd_clear && $past(en_wr))
    else $error("engine reset wrong");
  a_bus_reset_addr:
    assert property (bus_reset_seen && !req.wr ##1 |token_addr |-> !addr_match)
    else $error("address kept");
endmodule // usb_status_props

bind usb_device_status_control usb_status_props props_u (.clk(clk),
  .rst_n(rst_n), .req(req), .rdata(rdata), .xfer_done(xfer_done),
  .setup_seen(setup_seen), .bus_reset_seen(bus_reset_seen),
  .token_addr(token_addr), .addr_match(addr_match), .token_run(token_run),
  .wake_drive(wake_drive), .engine_reset(engine_reset),
  .odd_clear(odd_clear), .status_overflow(status_overflow));

// ### testbench/usb_host_model.sv
// Purpose: bus-side event source standing in for the host and engine
// Assumes: each event is a one-cycle pulse on clk
// Notes: result and frame fields are inverted once released; token address is held
`timescale 1ns/1ps
module usb_host_model
  import usb_stat_pkg::*;
(
  input logic clk, // clock
  output usb_stat_pkg::xfer_status_s xfer_info, // result
  output logic [10:0] sof_frame, // frame
  output logic [6:0] token_addr, // token address
  output logic [3:0] ev_pulse // done, setup, sof, bus reset
);
  initial
  begin
    {xfer_info, sof_frame, token_addr, ev_pulse} = '0;
  end
  // kind 0..3 pulses one event, kind 4 only moves the token address
  task automatic ev(input int kind, input logic [10:0] v);
    @(posedge clk);
    ev_pulse <= 4'(kind < 4) << kind;
    if (kind == 4)
      token_addr <= v[6:0];
    xfer_info <= v[5:0];
    sof_frame <= v;
    @(posedge clk);
    ev_pulse <= 4'h0;
    xfer_info <= ~v[5:0];
    sof_frame <= ~v;
  endtask
endmodule // usb_host_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the usb status/control block
// Assumes: host model makes engine events; registers on a strobe port
// Notes: fixed seed, random transfers beside hand-picked corners
`timescale 1ns/1ps
module testbench;
  import usb_stat_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata, d;
  logic [3:0] ep;
  xfer_status_s xi, xs;
  xfer_status_s q[$];
  logic [10:0] sof_frame, f;
  logic [6:0] token_addr, a;
  logic addr_match, token_run, wake_drive, irq;
  int mismatches = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  usb_device_status_control DUT (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .xfer_done(ep[0]), .xfer_info(xi), .setup_seen(ep[1]),
    .sof_seen(ep[2]), .sof_frame(sof_frame), .bus_reset_seen(ep[3]),
    .token_addr(token_addr), .addr_match(addr_match),
    .token_run(token_run), .wake_drive(wake_drive), .engine_reset(),
    .odd_clear(), .status_overflow(), .irq(irq));
  usb_host_model host (.clk(clk), .xfer_info(xi), .sof_frame(sof_frame),
    .token_addr(token_addr), .ev_pulse(ep));
  // one-cycle strobes; read data sampled mid-cycle after the strobe
  task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: ad, wdata: v};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chk(input string what, input logic [10:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    a = 7'($urandom(68663));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, OFF_FRAME_HI, 0);
    chk("frame high", 0, d);
    acc(1, OFF_CONTROL, 8'h01);
    acc(1, OFF_IRQ_MASK, 8'h01);
    acc(0, OFF_STATUS, 0);
    chk("empty status", 0, d);
    // five results, first a corner, last one meets a full fifo
    for (int i = 0; i < 5; i++)
    begin
      xs = (i == 0) ? 6'h1B : {4'($urandom_range(6)), 2'($urandom)};
      q.push_back(xs);
      host.ev(0, 11'(xs));
    end
    repeat (FIFO_DEPTH)
    begin
      chk("irq", 1, irq);
      xs = q.pop_front();
      acc(0, OFF_STATUS, 0);
      chk("status", {xs.pipe_index, xs.is_in, xs.odd_bank, 2'b00}, d);
      acc(1, OFF_IRQ_FLAGS, 8'h01);
    end
    chk("irq drained", 0, irq);
    $display("fifo test done");
    host.ev(1, 0);
    @(negedge clk);
    chk("halted", 0, token_run);
    acc(1, OFF_CONTROL, 8'h05);
    chk("resumed", 1, token_run);
    chk("wake", 1, wake_drive);
    acc(1, OFF_CONTROL, 8'h00);
    acc(1, OFF_CONTROL, 8'h03);
    acc(0, OFF_CONTROL, 0);
    chk("control", 8'h01, d);
    $display("control test done");
    acc(1, OFF_DEV_ID, {1'b1, a});
    host.ev(4, 11'(a));
    acc(0, OFF_DEV_ID, 0);
    chk("address", {1'b0, a}, d);
    chk("match", 1, addr_match);
    host.ev(3, 0);
    @(negedge clk);
    chk("match after bus reset", a == 7'h00, addr_match);
    $display("address test done");
    // sof capture, all-ones frame first
    for (int i = 0; i < 3; i++)
    begin
      f = (i == 0) ? 11'h7FF : 11'($urandom);
      host.ev(2, f);
      acc(0, OFF_FRAME_LO, 0);
      chk("frame low", f[7:0], d);
      acc(0, OFF_FRAME_HI, 0);
      chk("frame high", f[10:8], d);
    end
    $display("frame test done");
    close_out();
  end
endmodule // testbench
